// File: src/gct_consts.vh
// Constants for the general counter/timer block: register addresses,
// field positions, reset values and clock divide counts.
// Assumes an 8-bit special-function register bus with 8-bit addresses.
// Overview of operation
// - Timer1 gate bit adds gate input condition
// - Timer1 counts pin falls or divided clock
// - Timer1 modes: 13, 16, 8-reload, stopped
// - Timer0 gate bit adds gate input condition
// - Timer0 counts pin falls or divided clock
// - Timer0 modes: 13, 16, 8-reload, split
// - Timer2 divide bit: clock/12 or clock
// - Timer2 divide ignored in baud/counter mode
// - Timer1 divide bit: clock/12 or clock
// - Timer0 divide bit: clock/12 or clock
// - Unused divide register bits read zero
// - Timer0/1 counts as low/high byte registers
// - Timer2 counts as low/high byte registers
// - Timer2 counts pin falls when selected
// - Timer2 capture or auto-reload, off when stopped
// - Baud select bits force baud generator mode
// - Timer2 overflow can start a conversion
// - 13-bit rollover sets overflow flag
// - 8-bit overflow sets flag, reloads low from high
// - Split high byte runs on timer1 run
// - Run bit never alters count value
`ifndef GCT_CONSTS_VH
`define GCT_CONSTS_VH

// Register addresses
`define GCT_ADDR_T0_LOW      8'h8a
`define GCT_ADDR_T1_LOW      8'h8b
`define GCT_ADDR_T0_HIGH     8'h8c
`define GCT_ADDR_T1_HIGH     8'h8d
`define GCT_ADDR_CLK_DIV     8'h8e
`define GCT_ADDR_MODE_CFG    8'h89
`define GCT_ADDR_T2_LOW      8'hcc
`define GCT_ADDR_T2_HIGH     8'hcd

// Mode register fields
`define GCT_T1_GATE_BIT      7
`define GCT_T1_CSEL_BIT      6
`define GCT_T1_MODE_HI       5
`define GCT_T1_MODE_LO       4
`define GCT_T0_GATE_BIT      3
`define GCT_T0_CSEL_BIT      2
`define GCT_T0_MODE_HI       1
`define GCT_T0_MODE_LO       0

// Clock divide register fields
`define GCT_T2_DIV_BIT       5
`define GCT_T1_DIV_BIT       4
`define GCT_T0_DIV_BIT       3
`define GCT_CLK_DIV_MASK     8'h38

// Mode encodings
`define GCT_MODE_13BIT       2'h0
`define GCT_MODE_16BIT       2'h1
`define GCT_MODE_RELOAD8     2'h2
`define GCT_MODE_SPLIT       2'h3

// Reset values
`define GCT_RESET_BYTE       8'h00

// Clock divide counts
`define GCT_SLOW_DIVIDE      12
`define GCT_BAUD_DIVIDE      2

`endif

// File: src/gct_prescaler.v
// Divided clock enables for the counter/timers.
// Assumes one system clock; outputs are one-cycle enable pulses.
`include "gct_consts.vh"
`default_nettype none
module gct_prescaler #(
    parameter DIVIDE = `GCT_SLOW_DIVIDE
) (
    // Clock and reset
    input  wire       i_core_clk,
    input  wire       i_reset_n,
    // Enables
    output reg        o_div12_tick,
    output reg        o_div2_tick
);
    reg  [3:0] count;
    wire       wrap = (count == DIVIDE[3:0] - 4'h1);

    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            count        <= 4'h0;
            o_div12_tick <= 1'b0;
            o_div2_tick  <= 1'b0;
        end else begin
            count        <= wrap ? 4'h0 : count + 4'h1;
            o_div12_tick <= wrap;
            // Even divide count keeps halves regular
            o_div2_tick  <= count[0];
        end
    end
endmodule
`default_nettype wire

// File: src/gct_pin_sync.v
// Two-flop synchronisers with falling edge detect for external pins.
// Assumes pins are asynchronous and held at least two clocks per level.
`include "gct_consts.vh"
`default_nettype none
module gct_pin_sync #(
    parameter WIDTH = 5
) (
    // Clock and reset
    input  wire             i_core_clk,
    input  wire             i_reset_n,
    // Pins
    input  wire [WIDTH-1:0] i_pin,
    // Synchronised views
    output wire [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_fall
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta;
            reg sync;
            reg prev;
            always @(posedge i_core_clk) begin
                if (!i_reset_n) begin
                    meta <= 1'b1;
                    sync <= 1'b1;
                    prev <= 1'b1;
                end else begin
                    meta <= i_pin[g];
                    sync <= meta;
                    prev <= sync;
                end
            end
            // Edge seen only from the second flop onward
            assign o_level[g] = sync;
            assign o_fall[g]  = prev & ~sync;
        end
    endgenerate
endmodule
`default_nettype wire

// File: src/gct_timer_core.v
// Counter/timer core: mode and divide registers, three 16-bit counters.
// Assumes a single-cycle register bus on the system clock; run bits,
// flag clears and timer2 control bits come from neighbouring registers.
`include "gct_consts.vh"
`default_nettype none
module gct_timer_core (
    // Clock and reset
    input  wire       i_core_clk,
    input  wire       i_reset_n,
    // Register bus
    input  wire [7:0] i_sfr_addr,
    input  wire       i_sfr_wr,
    input  wire [7:0] i_sfr_wdata,
    input  wire       i_sfr_rd,
    output reg  [7:0] o_sfr_rdata,
    // Run and control bits held elsewhere
    input  wire       i_timer0_run,
    input  wire       i_timer1_run,
    input  wire       i_timer2_run,
    input  wire       i_timer2_count_select,
    input  wire       i_capture_reload_select,
    input  wire       i_tx_baud_clock_select,
    input  wire       i_rx_baud_clock_select,
    input  wire [15:0] i_timer2_reload,
    // Flag clears from software
    input  wire       i_timer0_overflow_clear,
    input  wire       i_timer1_overflow_clear,
    input  wire       i_timer2_overflow_clear,
    // External pins
    input  wire       i_timer0_count_pin,
    input  wire       i_timer1_count_pin,
    input  wire       i_timer2_count_pin,
    input  wire       i_timer0_gate_enable_input_n,
    input  wire       i_timer1_gate_enable_input_n,
    // Status and events
    output reg        o_timer0_overflow_flag,
    output reg        o_timer1_overflow_flag,
    output reg        o_timer2_overflow_flag,
    output reg        o_timer1_overflow_pulse,
    output reg        o_timer2_baud_tick,
    output reg        o_adc_start
);
    // Registers
    reg  [7:0] timer01_mode_config;
    reg  [7:0] timer_clock_divide;
    reg  [7:0] timer0_count_low;
    reg  [7:0] timer0_count_high;
    reg  [7:0] timer1_count_low;
    reg  [7:0] timer1_count_high;
    reg  [7:0] timer2_count_low;
    reg  [7:0] timer2_count_high;

    wire       div12_tick;
    wire       div2_tick;
    wire [4:0] pin_level;
    wire [4:0] pin_fall;

    gct_prescaler #(
        .DIVIDE (`GCT_SLOW_DIVIDE)
    ) u_prescaler (
        .i_core_clk   (i_core_clk),
        .i_reset_n    (i_reset_n),
        .o_div12_tick (div12_tick),
        .o_div2_tick  (div2_tick)
    );

    gct_pin_sync #(
        .WIDTH (5)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_pin      ({i_timer1_gate_enable_input_n, i_timer0_gate_enable_input_n, i_timer2_count_pin,
                      i_timer1_count_pin, i_timer0_count_pin}),
        .o_level    (pin_level),
        .o_fall     (pin_fall)
    );

    // Mode register fields
    wire       timer1_gate_enable   = timer01_mode_config[`GCT_T1_GATE_BIT];
    wire       timer1_count_select  = timer01_mode_config[`GCT_T1_CSEL_BIT];
    wire [1:0] timer1_mode_field    = timer01_mode_config[`GCT_T1_MODE_HI:`GCT_T1_MODE_LO];
    wire       timer0_gate_enable   = timer01_mode_config[`GCT_T0_GATE_BIT];
    wire       timer0_count_select  = timer01_mode_config[`GCT_T0_CSEL_BIT];
    wire [1:0] timer0_mode_field    = timer01_mode_config[`GCT_T0_MODE_HI:`GCT_T0_MODE_LO];
    wire       timer2_clock_divide  = timer_clock_divide[`GCT_T2_DIV_BIT];
    wire       timer1_clock_divide  = timer_clock_divide[`GCT_T1_DIV_BIT];
    wire       timer0_clock_divide  = timer_clock_divide[`GCT_T0_DIV_BIT];
    wire       timer0_split         = (timer0_mode_field == `GCT_MODE_SPLIT);

    // Time bases
    wire t0_base = timer0_clock_divide ? 1'b1 : div12_tick;
    wire t1_base = timer1_clock_divide ? 1'b1 : div12_tick;

    // Enables; gate inputs enable while high
    wire t0_enable = i_timer0_run & (~timer0_gate_enable | pin_level[3]);
    wire t1_enable = i_timer1_run & (~timer1_gate_enable | pin_level[4]);

    wire t0_tick = t0_enable & (timer0_count_select ? pin_fall[0] : t0_base);
    // Split timer0 takes timer1's pin and flag away
    wire t1_src  = (timer1_count_select & ~timer0_split) ? pin_fall[1] : t1_base;
    wire t1_tick = t1_enable & t1_src & (timer1_mode_field != `GCT_MODE_SPLIT);
    // Split high byte: timer0 time base only, under timer1 run
    wire th0_tick = timer0_split & i_timer1_run & t0_base;

    // Timer2 mode
    wire t2_baud  = i_tx_baud_clock_select | i_rx_baud_clock_select;
    wire t2_reload_mode = t2_baud | ~i_capture_reload_select;
    // Divide select bypassed for pin or baud counting
    wire t2_base  = i_timer2_count_select ? pin_fall[2] :
                    t2_baud ? div2_tick :
                    (timer2_clock_divide ? 1'b1 : div12_tick);
    wire t2_tick  = i_timer2_run & t2_base;

    // One count step: {overflow, high, low}
    function [16:0] step;
        input [1:0] mode;
        input [7:0] low;
        input [7:0] high;
        reg   [12:0] c13;
        begin
            c13 = {high, low[4:0]} + 13'h0001;
            case (mode)
                `GCT_MODE_13BIT:
                    step = {(c13 == 13'h0000), c13[12:5], low[7:5], c13[4:0]};
                `GCT_MODE_16BIT:
                    step = {({high, low} == 16'hffff), {high, low} + 16'h0001};
                `GCT_MODE_RELOAD8:
                    step = (low == 8'hff) ? {1'b1, high, high} : {1'b0, high, low + 8'h01};
                default:
                    step = {(low == 8'hff), high, low + 8'h01};
            endcase
        end
    endfunction

    wire [16:0] t0_next  = step(timer0_mode_field, timer0_count_low, timer0_count_high);
    wire [16:0] t1_next  = step(timer1_mode_field, timer1_count_low, timer1_count_high);
    wire [16:0] t2_sum   = {1'b0, timer2_count_high, timer2_count_low} + 17'h00001;
    wire        t0_ovf   = t0_tick & t0_next[16];
    wire        t1_ovf   = t1_tick & t1_next[16];
    wire        th0_ovf  = th0_tick & (timer0_count_high == 8'hff);
    wire        t2_ovf   = t2_tick & t2_sum[16];

    // Bus write strobes
    wire wr_mode = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_MODE_CFG);
    wire wr_div  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_CLK_DIV);
    wire wr_t0l  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T0_LOW);
    wire wr_t0h  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T0_HIGH);
    wire wr_t1l  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T1_LOW);
    wire wr_t1h  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T1_HIGH);
    wire wr_t2l  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T2_LOW);
    wire wr_t2h  = i_sfr_wr & (i_sfr_addr == `GCT_ADDR_T2_HIGH);

    // Configuration registers
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            timer01_mode_config <= `GCT_RESET_BYTE;
            timer_clock_divide  <= `GCT_RESET_BYTE;
        end else begin
            if (wr_mode) begin
                timer01_mode_config <= i_sfr_wdata;
            end
            if (wr_div) begin
                timer_clock_divide <= i_sfr_wdata & `GCT_CLK_DIV_MASK;
            end
        end
    end

    // Count registers; a bus write beats a count in the same cycle.
    // Run bits only gate ticks, never touch the count.
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            timer0_count_low  <= `GCT_RESET_BYTE;
            timer0_count_high <= `GCT_RESET_BYTE;
            timer1_count_low  <= `GCT_RESET_BYTE;
            timer1_count_high <= `GCT_RESET_BYTE;
            timer2_count_low  <= `GCT_RESET_BYTE;
            timer2_count_high <= `GCT_RESET_BYTE;
        end else begin
            if (wr_t0l) begin
                timer0_count_low <= i_sfr_wdata;
            end else if (t0_tick) begin
                timer0_count_low <= t0_next[7:0];
            end
            if (wr_t0h) begin
                timer0_count_high <= i_sfr_wdata;
            end else if (th0_tick) begin
                timer0_count_high <= timer0_count_high + 8'h01;
            end else if (t0_tick & ~timer0_split) begin
                timer0_count_high <= t0_next[15:8];
            end
            if (wr_t1l) begin
                timer1_count_low <= i_sfr_wdata;
            end else if (t1_tick) begin
                timer1_count_low <= t1_next[7:0];
            end
            if (wr_t1h) begin
                timer1_count_high <= i_sfr_wdata;
            end else if (t1_tick) begin
                timer1_count_high <= t1_next[15:8];
            end
            if (wr_t2l) begin
                timer2_count_low <= i_sfr_wdata;
            end else if (t2_ovf & t2_reload_mode) begin
                timer2_count_low <= i_timer2_reload[7:0];
            end else if (t2_tick) begin
                timer2_count_low <= t2_sum[7:0];
            end
            if (wr_t2h) begin
                timer2_count_high <= i_sfr_wdata;
            end else if (t2_ovf & t2_reload_mode) begin
                timer2_count_high <= i_timer2_reload[15:8];
            end else if (t2_tick) begin
                timer2_count_high <= t2_sum[15:8];
            end
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_timer0_overflow_flag  <= 1'b0;
            o_timer1_overflow_flag  <= 1'b0;
            o_timer2_overflow_flag  <= 1'b0;
            o_timer1_overflow_pulse <= 1'b0;
            o_timer2_baud_tick      <= 1'b0;
            o_adc_start             <= 1'b0;
        end else begin
            o_timer0_overflow_flag <= t0_ovf |
                                      (o_timer0_overflow_flag & ~i_timer0_overflow_clear);
            // In split mode only the high byte owns timer1's flag
            o_timer1_overflow_flag <= (timer0_split ? th0_ovf : t1_ovf) |
                                      (o_timer1_overflow_flag & ~i_timer1_overflow_clear);
            o_timer2_overflow_flag <= (t2_ovf & ~t2_baud) |
                                      (o_timer2_overflow_flag & ~i_timer2_overflow_clear);
            // Timer1 overflow still feeds baud logic in split mode
            o_timer1_overflow_pulse <= t1_ovf;
            o_timer2_baud_tick      <= t2_ovf & t2_baud;
            o_adc_start             <= t2_ovf;
        end
    end

    // Read data, registered; unmapped addresses read zero
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                `GCT_ADDR_MODE_CFG: o_sfr_rdata <= timer01_mode_config;
                `GCT_ADDR_CLK_DIV:  o_sfr_rdata <= timer_clock_divide & `GCT_CLK_DIV_MASK;
                `GCT_ADDR_T0_LOW:   o_sfr_rdata <= timer0_count_low;
                `GCT_ADDR_T0_HIGH:  o_sfr_rdata <= timer0_count_high;
                `GCT_ADDR_T1_LOW:   o_sfr_rdata <= timer1_count_low;
                `GCT_ADDR_T1_HIGH:  o_sfr_rdata <= timer1_count_high;
                `GCT_ADDR_T2_LOW:   o_sfr_rdata <= timer2_count_low;
                `GCT_ADDR_T2_HIGH:  o_sfr_rdata <= timer2_count_high;
                default:            o_sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: bench/gct_pin_model.sv
// Far-side model: external count pins and gate inputs that enable while high.
// Assumes the bench calls its tasks from a falling clock edge.
`default_nettype none
module gct_pin_model (
    input  wire logic       i_core_clk,
    output var  logic [2:0] o_count_pin,
    output var  logic [1:0] o_gate_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_count_pin = 3'h7;
        o_gate_n    = 2'h0;
    end
    // Levels held three clocks, above the two-clock sampling minimum
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(negedge i_core_clk);
            o_count_pin[idx] = 1'b0;
            repeat (3) @(negedge i_core_clk);
            o_count_pin[idx] = 1'b1;
            repeat (2) @(negedge i_core_clk);
        end
    endtask
    task automatic set_gate(input logic [1:0] g);
        @(negedge i_core_clk);
        o_gate_n = g;
    endtask
endmodule
`default_nettype wire

// File: bench/gct_timer_checker.sv
// Port checker for the counter/timer core.
// Assumes binding to gct_timer_core on its single clock.
`default_nettype none
module gct_timer_checker (
    input wire logic       i_core_clk,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       i_timer0_run,
    input wire logic       i_timer1_run,
    input wire logic       i_timer2_run,
    input wire logic       i_tx_baud_clock_select,
    input wire logic       i_rx_baud_clock_select,
    input wire logic       i_timer0_overflow_clear,
    input wire logic       o_timer0_overflow_flag,
    input wire logic       o_timer1_overflow_flag,
    input wire logic       o_timer2_overflow_flag,
    input wire logic       o_timer2_baud_tick,
    input wire logic       o_adc_start
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    wire baud_sel = i_tx_baud_clock_select | i_rx_baud_clock_select;
    wire mapped   = (i_sfr_addr >= 8'h89 && i_sfr_addr <= 8'h8e) || i_sfr_addr == 8'hcc || i_sfr_addr == 8'hcd;
    a_unmapped_zero: assert property (i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved without a read");
    a_divide_unused: assert property (i_sfr_rd && i_sfr_addr == 8'h8e |=> (o_sfr_rdata & 8'hc7) == 8'h00)
        else $error("unused divide bits not zero");
    a_baud_no_flag: assert property (baud_sel && !o_timer2_overflow_flag |=> !o_timer2_overflow_flag)
        else $error("timer2 flag set in baud mode");
    a_baud_tick_mode: assert property (o_timer2_baud_tick |-> $past(baud_sel) && $past(i_timer2_run))
        else $error("baud tick outside baud mode");
    a_baud_adc_start: assert property (o_timer2_baud_tick |-> o_adc_start)
        else $error("baud overflow without conversion start");
    a_timer2_off: assert property (!i_timer2_run |=> !o_adc_start && !o_timer2_baud_tick)
        else $error("timer2 event while stopped");
    a_flag0_sticky: assert property (o_timer0_overflow_flag && !i_timer0_overflow_clear |=> o_timer0_overflow_flag)
        else $error("timer0 flag dropped without clear");
    a_flag0_run: assert property ($rose(o_timer0_overflow_flag) |-> $past(i_timer0_run))
        else $error("timer0 flag set while not running");
    a_flag1_run: assert property ($rose(o_timer1_overflow_flag) |-> $past(i_timer1_run))
        else $error("timer1 flag set while timer1 run low");
endmodule
bind gct_timer_core gct_timer_checker chk_u (.*);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the counter/timer core over its register bus.
// Assumes the core's registered read data and level run/control ports.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        wr     = 1'b0;
    logic        rd     = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [7:0]  wdata  = 8'h00;
    logic [2:0]  run    = 3'h0;
    logic [2:0]  clr    = 3'h0;
    logic [3:0]  t2c    = 4'h0;
    logic [15:0] reload = 16'h0000;
    logic [7:0]  regs [9] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'hcc, 8'hcd, 8'h80};
    wire  [7:0]  rdata;
    wire  [2:0]  flag;
    wire  [2:0]  pin;
    wire  [1:0]  gate_n;
    wire         baud_tick;
    wire         adc;
    wire         t1_pulse;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n_adc = 0;
    int          n_baud = 0;
    int          n_t1p = 0;
    gct_pin_model pin_u (.i_core_clk(clk), .o_count_pin(pin), .o_gate_n(gate_n));
    gct_timer_core dut_u (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_timer0_run(run[0]), .i_timer1_run(run[1]),
        .i_timer2_run(run[2]), .i_timer2_count_select(t2c[3]), .i_capture_reload_select(t2c[2]),
        .i_tx_baud_clock_select(t2c[1]), .i_rx_baud_clock_select(t2c[0]), .i_timer2_reload(reload),
        .i_timer0_overflow_clear(clr[0]), .i_timer1_overflow_clear(clr[1]), .i_timer2_overflow_clear(clr[2]),
        .i_timer0_count_pin(pin[0]), .i_timer1_count_pin(pin[1]), .i_timer2_count_pin(pin[2]),
        .i_timer0_gate_enable_input_n(gate_n[0]), .i_timer1_gate_enable_input_n(gate_n[1]), .o_timer0_overflow_flag(flag[0]),
        .o_timer1_overflow_flag(flag[1]), .o_timer2_overflow_flag(flag[2]), .o_timer1_overflow_pulse(t1_pulse),
        .o_timer2_baud_tick(baud_tick), .o_adc_start(adc));
    initial begin
        forever #50 clk = ~clk;
    end
    // Run is far shorter than this; a hang lands in the report
    // Pulses counted at the falling edge, where they have settled
    always @(negedge clk) begin
        cycles++;
        if (adc === 1'b1) n_adc++;
        if (baud_tick === 1'b1) n_baud++;
        if (t1_pulse === 1'b1) n_t1p++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    task automatic set16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        wrb(lo, v[7:0]);
        wrb(hi, v[15:8]);
    endtask
    task automatic c16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] exp);
        logic [7:0] l;
        logic [7:0] h;
        rdb(lo, l);
        rdb(hi, h);
        chk({h, l}, exp);
    endtask
    task automatic go(input logic [2:0] m, input int n);
        @(negedge clk);
        run = m;
        repeat (n) @(negedge clk);
        run = 3'h0;
    endtask
    task automatic clrf(input logic [2:0] m);
        @(negedge clk);
        clr = m;
        @(negedge clk);
        clr = 3'h0;
    endtask
    initial begin
        logic [7:0] d;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        foreach (regs[i]) begin
            rdb(regs[i], d);
            chk({8'h00, d}, 16'h0000);
        end
        foreach (regs[i]) wrb(regs[i], 8'hff);
        foreach (regs[i]) begin
            rdb(regs[i], d);
            chk({8'h00, d}, regs[i] == 8'h8e ? 16'h0038 : regs[i] == 8'h80 ? 16'h0000 : 16'h00ff);
        end
        // Carry into the high byte, both timers free of gating
        wrb(8'h89, 8'h11);
        wrb(8'h8e, 8'h18);
        set16(8'h8a, 8'h8c, 16'h00fe);
        set16(8'h8b, 8'h8d, 16'h00fe);
        go(3'h3, 10);
        c16(8'h8a, 8'h8c, 16'h0108);
        c16(8'h8b, 8'h8d, 16'h0108);
        wrb(8'h8e, 8'h10);
        go(3'h3, 24);
        c16(8'h8a, 8'h8c, 16'h010a);
        c16(8'h8b, 8'h8d, 16'h0120);
        wrb(8'h8e, 8'h08);
        go(3'h3, 24);
        c16(8'h8a, 8'h8c, 16'h0122);
        c16(8'h8b, 8'h8d, 16'h0122);
        // Gated: gates low hold both, then high lets them run
        wrb(8'h89, 8'h99);
        wrb(8'h8e, 8'h18);
        go(3'h3, 10);
        c16(8'h8a, 8'h8c, 16'h0122);
        c16(8'h8b, 8'h8d, 16'h0122);
        pin_u.set_gate(2'h3);
        repeat (4) @(negedge clk);
        go(3'h3, 10);
        c16(8'h8a, 8'h8c, 16'h012c);
        c16(8'h8b, 8'h8d, 16'h012c);
        // External pin counting ignores the fast clock
        wrb(8'h89, 8'h55);
        run = 3'h3;
        pin_u.pulse(0, 3);
        pin_u.pulse(1, 5);
        repeat (6) @(negedge clk);
        run = 3'h0;
        c16(8'h8a, 8'h8c, 16'h012f);
        c16(8'h8b, 8'h8d, 16'h0131);
        // 13-bit wrap keeps low-byte bits 7:5
        wrb(8'h89, 8'h00);
        set16(8'h8a, 8'h8c, 16'hfffe);
        set16(8'h8b, 8'h8d, 16'hfffe);
        go(3'h3, 2);
        c16(8'h8a, 8'h8c, 16'h00e0);
        c16(8'h8b, 8'h8d, 16'h00e0);
        chk({14'h0000, flag[1:0]}, 16'h0003);
        clrf(3'h3);
        chk({14'h0000, flag[1:0]}, 16'h0000);
        wrb(8'h89, 8'h12);
        set16(8'h8a, 8'h8c, 16'h80fe);
        go(3'h1, 3);
        c16(8'h8a, 8'h8c, 16'h8081);
        chk({15'h0000, flag[0]}, 16'h0001);
        wrb(8'h89, 8'h32);
        go(3'h2, 10);
        c16(8'h8b, 8'h8d, 16'h00e0);
        // Split: high byte runs under timer1 run, sets flag1
        // Timer1 reload overflow still pulses; flag belongs to high byte
        wrb(8'h89, 8'h23);
        set16(8'h8a, 8'h8c, 16'hfe00);
        set16(8'h8b, 8'h8d, 16'h80ff);
        n_t1p = 0;
        go(3'h2, 3);
        c16(8'h8a, 8'h8c, 16'h0100);
        c16(8'h8b, 8'h8d, 16'h8082);
        chk({15'h0000, flag[1]}, 16'h0001);
        chk(16'(n_t1p), 16'h0001);
        // Timer2 capture wrap, auto-reload, divide by 12
        wrb(8'h8e, 8'h20);
        t2c = 4'h4;
        set16(8'hcc, 8'hcd, 16'hfffe);
        go(3'h4, 3);
        c16(8'hcc, 8'hcd, 16'h0001);
        chk({15'h0000, flag[2]}, 16'h0001);
        t2c = 4'h0;
        reload = 16'h1234;
        set16(8'hcc, 8'hcd, 16'hfffe);
        go(3'h4, 3);
        c16(8'hcc, 8'hcd, 16'h1235);
        wrb(8'h8e, 8'h00);
        set16(8'hcc, 8'hcd, 16'h0000);
        go(3'h4, 24);
        c16(8'hcc, 8'hcd, 16'h0002);
        // Baud mode: half-rate ticks, reload, no flag, conversion start
        clrf(3'h4);
        t2c = 4'h6;
        reload = 16'habcd;
        set16(8'hcc, 8'hcd, 16'hfffe);
        n_adc = 0;
        go(3'h4, 6);
        c16(8'hcc, 8'hcd, 16'habce);
        chk({15'h0000, flag[2]}, 16'h0000);
        chk(16'(n_adc), 16'h0001);
        chk(16'(n_baud), 16'h0001);
        t2c = 4'hc;
        set16(8'hcc, 8'hcd, 16'h0000);
        run = 3'h4;
        pin_u.pulse(2, 2);
        repeat (6) @(negedge clk);
        run = 3'h0;
        c16(8'hcc, 8'hcd, 16'h0002);
        finish_test();
    end
endmodule
`default_nettype wire
